// file: design/lsr_pkg.sv
// Shared constants and carriers for the LIN serial receive status block
package lsr_pkg;
   localparam int unsigned OVERSAMPLE = 16;
   localparam logic [3:0] VERIFY_SAMPLE = 4'h9;
   localparam logic [3:0] MID_SAMPLE = 4'h7;
   localparam logic [3:0] IDLE_BITS = 4'ha;
   localparam logic [15:0] BAUD_DIV_RESET = 16'h0036;
   localparam logic [7:0] LIN_TX_RESET = 8'h00;
   localparam logic [3:0] WAKE_MIN_SAMPLES = 4'h8;

   typedef struct packed {
      logic receive_full_flag;
      logic overrun_flag;
      logic parity_error_flag;
      logic frame_error_flag;
      logic idle_flag;
      logic lin_receive_ready_flag;
   } lsr_flags_type;

   typedef struct packed {
      logic unrequested_data_flag;
      logic lin_bit_error_flag;
      logic lin_frame_overflow_flag;
      logic lin_crc_error_flag;
      logic lin_checksum_error_flag;
   } lsr_lin_err_type;

   typedef struct packed {
      logic lin_transaction_active;
      logic lin_wakeup_active;
      logic dma_request_pending;
   } lsr_activity_type;
endpackage

// file: design/lsr_baud_tick.sv
// Oversample tick generator for the receiver
`timescale 1ns/1ns
module lsr_baud_tick #(
   parameter int unsigned DIV_WIDTH = 16
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [DIV_WIDTH-1:0] divisor_i,
   output logic tick_o
);
   if (DIV_WIDTH < 2) begin : g_width_check
      $error("DIV_WIDTH too small");
   end
   logic [DIV_WIDTH-1:0] count;
   logic [DIV_WIDTH-1:0] next_count;
   logic next_tick;
   always_comb begin
      next_tick = 1'b0;
      next_count = count + {{(DIV_WIDTH-1){1'b0}}, 1'b1};
      if (count >= divisor_i - {{(DIV_WIDTH-1){1'b0}}, 1'b1}) begin
         next_count = '0;
         next_tick = 1'b1;
      end
   end
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         count <= '0;
         tick_o <= 1'b0;
      end else begin
         count <= next_count;
         tick_o <= next_tick;
      end
   end
endmodule // lsr_baud_tick

// file: design/lsr_receiver.sv
// Receive path, flag timing and activity status of the LIN serial interface
//
// What this block does
// RULE1 - Idle detection starts counting only after the last stop bit is received.
// RULE2 - Bit timing re-synchronises only on the falling edge of a start bit.
// RULE3 - LIN transaction active reads set while a LIN transaction is ongoing.
// RULE4 - LIN wake-up active reads set while wake-up signal reception is ongoing.
// RULE5 - DMA request pending is set while transmit or receive DMA request waits.
// RULE6 - LIN transmit register reads back the last value written.
// RULE7 - Overrun and parity flags set at tenth sample of last stop bit.
// RULE8 - Receive full flag set at tenth stop sample, never in DMA receive mode.
// RULE9 - LIN error flags set at tenth sample of the last stop bit.
// RULE10 - LIN receive ready set at tenth stop sample, never in DMA receive mode.
// RULE11 - In DMA receive mode each byte raises a receive DMA request instead.
`timescale 1ns/1ns
module lsr_receiver #(
   parameter int unsigned DIV_WIDTH = 16
) (
   input wire logic SYS_CLK_I,
   input wire logic RESETN_I,
   input wire logic RXD_I,
   input wire logic [DIV_WIDTH-1:0] BAUD_DIV_I,
   input wire logic PARITY_EN_I,
   input wire logic PARITY_ODD_I,
   input wire logic DMA_RX_EN_I,
   input wire logic LIN_MODE_I,
   input wire logic LIN_FRAME_START_I,
   input wire logic LIN_FRAME_END_I,
   input wire logic LIN_RX_EXPECTED_I,
   input wire logic LIN_TX_BIT_I,
   input wire logic LIN_TX_DRIVING_I,
   input wire logic LIN_LAST_BYTE_I,
   input wire logic LIN_CRC_BAD_I,
   input wire logic LIN_CHECKSUM_BAD_I,
   input wire logic LIN_TX_WRITE_I,
   input wire logic [7:0] LIN_TX_DATA_I,
   input wire logic TX_DMA_REQ_I,
   input wire logic RX_DMA_ACK_I,
   input wire logic DATA_READ_I,
   input wire lsr_pkg::lsr_flags_type FLAGS_CLEAR_I,
   input wire lsr_pkg::lsr_lin_err_type LIN_ERR_CLEAR_I,
   output logic [7:0] RX_DATA_O,
   output logic [7:0] LIN_TX_READBACK_O,
   output lsr_pkg::lsr_flags_type FLAGS_O,
   output lsr_pkg::lsr_lin_err_type LIN_ERR_O,
   output lsr_pkg::lsr_activity_type ACTIVITY_O,
   output logic RX_DMA_REQ_O
);
   if (DIV_WIDTH < 5) begin : g_width_check
      $error("DIV_WIDTH too small for the reset divisor");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchroniser: a change counts once stages two and three agree
   logic rx_s1;
   logic rx_s2;
   logic rx_s3;
   logic rx_level;
   logic next_rx_level;
   logic tick;
   always_comb begin
      next_rx_level = rx_level;
      if (rx_s2 == rx_s3) next_rx_level = rx_s3;
   end
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESETN_I) begin
         rx_s1 <= 1'b1;
         rx_s2 <= 1'b1;
         rx_s3 <= 1'b1;
         rx_level <= 1'b1;
      end else begin
         rx_s1 <= RXD_I;
         rx_s2 <= rx_s1;
         rx_s3 <= rx_s2;
         rx_level <= next_rx_level;
      end
   end

   lsr_baud_tick #(.DIV_WIDTH(DIV_WIDTH)) u_tick (
      .clk_i(SYS_CLK_I),
      .resetn_i(RESETN_I),
      .divisor_i(BAUD_DIV_I),
      .tick_o(tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Receive state machine
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_START = 4'b0010,
      ST_DATA = 4'b0100,
      ST_STOP = 4'b1000
   } lsr_rx_state_type;

   lsr_rx_state_type state;
   lsr_rx_state_type next_state;
   logic [3:0] sample;
   logic [3:0] next_sample;
   logic [3:0] bit_count;
   logic [3:0] next_bit_count;
   logic [8:0] shift;
   logic [8:0] next_shift;
   logic rx_prev;
   logic stop_done;
   logic stop_ok;
   logic [3:0] idle_count;
   logic [3:0] next_idle_count;
   logic idle_armed;
   logic next_idle_armed;
   logic [3:0] wake_count;
   logic [3:0] next_wake_count;
   logic wake_active;
   logic next_wake_active;
   logic lin_bit_mismatch;
   logic next_lin_bit_mismatch;
   logic [3:0] frame_bits;

   assign frame_bits = PARITY_EN_I ? 4'h9 : 4'h8;

   always_comb begin
      next_state = state;
      next_sample = sample;
      next_bit_count = bit_count;
      next_shift = shift;
      next_lin_bit_mismatch = lin_bit_mismatch;
      stop_done = 1'b0;
      stop_ok = 1'b0;
      unique case (state)
         ST_IDLE: begin
            // Only a falling start edge realigns the sample phase [RULE2]
            if (rx_prev && !rx_level) begin
               next_state = ST_START;
               next_sample = '0;
               next_lin_bit_mismatch = 1'b0;
            end
         end
         ST_START: begin
            if (tick) begin
               next_sample = sample + 4'h1;
               if (sample == lsr_pkg::MID_SAMPLE && rx_level) next_state = ST_IDLE;
               if (sample == 4'hf) begin
                  next_state = ST_DATA;
                  next_bit_count = '0;
               end
            end
         end
         ST_DATA: begin
            // Data edges are not used for timing; phase runs free from the start edge
            if (tick) begin
               next_sample = sample + 4'h1;
               if (sample == lsr_pkg::MID_SAMPLE) begin
                  next_shift = {rx_level, shift[8:1]};
                  if (LIN_TX_DRIVING_I && (rx_level != LIN_TX_BIT_I)) next_lin_bit_mismatch = 1'b1;
               end
               if (sample == 4'hf) begin
                  next_bit_count = bit_count + 4'h1;
                  if (bit_count == frame_bits - 4'h1) next_state = ST_STOP;
               end
            end
         end
         ST_STOP: begin
            if (tick) begin
               next_sample = sample + 4'h1;
               // Verification ends at the tenth sample, so flags need not wait for the bit end
               if (sample == lsr_pkg::VERIFY_SAMPLE) begin
                  stop_done = 1'b1;
                  stop_ok = rx_level;
                  next_state = ST_IDLE;
               end
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // Idle counting is armed only from the stop bit [RULE1]
   always_comb begin
      next_idle_armed = idle_armed;
      next_idle_count = idle_count;
      if (stop_done) begin
         next_idle_armed = 1'b1;
         next_idle_count = '0;
      end else if (state != ST_IDLE) begin
         next_idle_armed = 1'b0;
      end else if (idle_armed && tick && rx_level) begin
         next_idle_count = idle_count + 4'h1;
      end
   end

   // Wake-up is a dominant pulse seen outside a LIN frame [RULE4]
   always_comb begin
      next_wake_count = wake_count;
      next_wake_active = wake_active;
      if (!LIN_MODE_I || rx_level) begin
         next_wake_count = '0;
         next_wake_active = 1'b0;
      end else if (!ACTIVITY_O.lin_transaction_active && tick) begin
         if (wake_count != 4'hf) next_wake_count = wake_count + 4'h1;
         if (wake_count >= lsr_pkg::WAKE_MIN_SAMPLES) next_wake_active = 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (!RESETN_I) begin
         state <= ST_IDLE;
         sample <= '0;
         bit_count <= '0;
         shift <= '0;
         rx_prev <= 1'b1;
         idle_count <= '0;
         idle_armed <= 1'b0;
         wake_count <= '0;
         wake_active <= 1'b0;
         lin_bit_mismatch <= 1'b0;
      end else begin
         state <= next_state;
         sample <= next_sample;
         bit_count <= next_bit_count;
         shift <= next_shift;
         rx_prev <= rx_level;
         idle_count <= next_idle_count;
         idle_armed <= next_idle_armed;
         wake_count <= next_wake_count;
         wake_active <= next_wake_active;
         lin_bit_mismatch <= next_lin_bit_mismatch;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flags: hardware set wins over a clear in the same cycle
   lsr_pkg::lsr_flags_type next_flags;
   lsr_pkg::lsr_lin_err_type next_lin_err;
   logic [7:0] next_rx_data;
   logic next_rx_dma_req;
   logic next_lin_active;
   logic [7:0] next_lin_tx;
   logic parity_bad;
   logic [7:0] data_byte;

   assign data_byte = PARITY_EN_I ? shift[7:0] : shift[8:1];
   assign parity_bad = PARITY_EN_I && ((^shift) ^ PARITY_ODD_I);

   always_comb begin
      next_flags = FLAGS_O & ~FLAGS_CLEAR_I;
      next_lin_err = LIN_ERR_O & ~LIN_ERR_CLEAR_I;
      next_rx_data = RX_DATA_O;
      next_rx_dma_req = RX_DMA_REQ_O && !RX_DMA_ACK_I;
      next_lin_active = ACTIVITY_O.lin_transaction_active;
      next_lin_tx = LIN_TX_READBACK_O;
      if (DATA_READ_I) next_flags.receive_full_flag = 1'b0;
      if (idle_armed && tick && rx_level && idle_count == lsr_pkg::IDLE_BITS * 4'h0 + 4'hf) begin
         next_flags.idle_flag = 1'b1; // [RULE1]
      end
      if (stop_done) begin
         next_rx_data = data_byte;
         next_flags.overrun_flag = FLAGS_O.overrun_flag | FLAGS_O.receive_full_flag | RX_DMA_REQ_O; // [RULE7]
         next_flags.parity_error_flag = FLAGS_O.parity_error_flag | parity_bad; // [RULE7]
         next_flags.frame_error_flag = FLAGS_O.frame_error_flag | !stop_ok;
         if (DMA_RX_EN_I) begin
            next_rx_dma_req = 1'b1; // [RULE11]
         end else begin
            next_flags.receive_full_flag = 1'b1; // [RULE8]
            if (LIN_MODE_I && LIN_RX_EXPECTED_I) next_flags.lin_receive_ready_flag = 1'b1; // [RULE10]
         end
         if (LIN_MODE_I) begin
            // All LIN error flags share the stop-verification moment [RULE9]
            if (!ACTIVITY_O.lin_transaction_active) next_lin_err.unrequested_data_flag = 1'b1;
            if (lin_bit_mismatch) next_lin_err.lin_bit_error_flag = 1'b1;
            if (ACTIVITY_O.lin_transaction_active && !LIN_RX_EXPECTED_I && !LIN_TX_DRIVING_I) begin
               next_lin_err.lin_frame_overflow_flag = 1'b1;
            end
            if (LIN_LAST_BYTE_I && LIN_CRC_BAD_I) next_lin_err.lin_crc_error_flag = 1'b1;
            if (LIN_LAST_BYTE_I && LIN_CHECKSUM_BAD_I) next_lin_err.lin_checksum_error_flag = 1'b1;
         end
      end
      // Active from frame start to frame end [RULE3]
      if (!LIN_MODE_I || LIN_FRAME_END_I) next_lin_active = 1'b0;
      else if (LIN_FRAME_START_I) next_lin_active = 1'b1;
      if (LIN_TX_WRITE_I) next_lin_tx = LIN_TX_DATA_I; // [RULE6]
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (!RESETN_I) begin
         FLAGS_O <= '0;
         LIN_ERR_O <= '0;
         RX_DATA_O <= '0;
         RX_DMA_REQ_O <= 1'b0;
         ACTIVITY_O <= '0;
         LIN_TX_READBACK_O <= lsr_pkg::LIN_TX_RESET;
      end else begin
         FLAGS_O <= next_flags;
         LIN_ERR_O <= next_lin_err;
         RX_DATA_O <= next_rx_data;
         RX_DMA_REQ_O <= next_rx_dma_req;
         ACTIVITY_O.lin_transaction_active <= next_lin_active;
         ACTIVITY_O.lin_wakeup_active <= next_wake_active;
         // Pending while either direction waits for service [RULE5]
         ACTIVITY_O.dma_request_pending <= next_rx_dma_req | TX_DMA_REQ_I;
         LIN_TX_READBACK_O <= next_lin_tx;
      end
   end
endmodule // lsr_receiver

// file: verif/lsr_receiver_props.sv
// Checker for the receive status block, bound to its top ports
`timescale 1ns/1ns
module lsr_receiver_props (
   input wire logic SYS_CLK_I,
   input wire logic RESETN_I,
   input wire logic RXD_I,
   input wire logic DMA_RX_EN_I,
   input wire logic LIN_MODE_I,
   input wire logic LIN_FRAME_START_I,
   input wire logic LIN_FRAME_END_I,
   input wire logic LIN_TX_WRITE_I,
   input wire logic [7:0] LIN_TX_DATA_I,
   input wire logic TX_DMA_REQ_I,
   input wire logic [7:0] LIN_TX_READBACK_O,
   input wire lsr_pkg::lsr_flags_type FLAGS_O,
   input wire lsr_pkg::lsr_lin_err_type LIN_ERR_O,
   input wire lsr_pkg::lsr_activity_type ACTIVITY_O,
   input wire logic RX_DMA_REQ_O
);
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RESETN_I);
   ////////////////////////////////////////////////////////////////////////////
   property p_full_dma; $rose(FLAGS_O.receive_full_flag) |-> !$past(DMA_RX_EN_I); endproperty
   a_full_dma: assert property (p_full_dma) else $error("receive full set in dma mode");
   property p_rdy_dma; $rose(FLAGS_O.lin_receive_ready_flag) |-> !$past(DMA_RX_EN_I); endproperty
   a_rdy_dma: assert property (p_rdy_dma) else $error("receive ready set in dma mode");
   property p_dma_req; $rose(RX_DMA_REQ_O) |-> $past(DMA_RX_EN_I); endproperty
   a_dma_req: assert property (p_dma_req) else $error("dma request outside dma mode");
   property p_pend; (TX_DMA_REQ_I || RX_DMA_REQ_O) |-> ##[0:2] ACTIVITY_O.dma_request_pending; endproperty
   a_pend: assert property (p_pend) else $error("dma pending not shown");
   property p_readback; LIN_TX_WRITE_I |=> LIN_TX_READBACK_O == $past(LIN_TX_DATA_I); endproperty
   a_readback: assert property (p_readback) else $error("readback differs from write");
   // Overrun only makes sense while the previous byte is still unclaimed
   property p_overrun; $rose(FLAGS_O.overrun_flag) |-> $past(FLAGS_O.receive_full_flag) || $past(RX_DMA_REQ_O);
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun without pending byte");
   property p_unreq;
      $rose(LIN_ERR_O.unrequested_data_flag) |-> $past(LIN_MODE_I) && !$past(ACTIVITY_O.lin_transaction_active);
   endproperty
   a_unreq: assert property (p_unreq) else $error("unrequested flag inside transaction");
   property p_act_on; LIN_FRAME_START_I && !LIN_FRAME_END_I |-> ##[1:2] ACTIVITY_O.lin_transaction_active; endproperty
   a_act_on: assert property (p_act_on) else $error("transaction active missing");
   property p_act_off; LIN_FRAME_END_I |-> ##[1:2] !ACTIVITY_O.lin_transaction_active; endproperty
   a_act_off: assert property (p_act_off) else $error("transaction active stuck");
   property p_wake; $rose(ACTIVITY_O.lin_wakeup_active) |-> !$past(RXD_I, 8); endproperty
   a_wake: assert property (p_wake) else $error("wake active with line high");
   property p_idle; $rose(FLAGS_O.idle_flag) |-> $past(RXD_I, 8); endproperty
   a_idle: assert property (p_idle) else $error("idle flag with line low");
endmodule // lsr_receiver_props

// file: verif/lsr_line_model.sv
// Far-side serial line model that sends frames onto the receive pin
`timescale 1ns/1ns
module lsr_line_model #(
   parameter int BIT_CLKS = 32
) (
   input wire logic clk_i,
   output logic line_o
);
   // Line idles high, as a pulled-up bus would
   initial line_o = 1'b1;
   task automatic bit_out(input logic v);
      line_o = v;
      repeat (BIT_CLKS) @(posedge clk_i);
      #1;
   endtask
   // Start bit, n bits LSB first, one stop bit; entered just after an edge
   task automatic send(input logic [8:0] d, input int n);
      bit_out(1'b0);
      for (int i = 0; i < n; i++) begin
         bit_out(d[i]);
      end
      bit_out(1'b1);
   endtask
endmodule // lsr_line_model

// file: verif/lsr_receiver_test.sv
// Self-checking bench for the LIN serial receive status block
`timescale 1ns/1ns
module lsr_receiver_test;
   logic SYS_CLK_I = 1'b0, RESETN_I, RXD_I, PARITY_EN_I, PARITY_ODD_I, DMA_RX_EN_I, LIN_MODE_I;
   logic LIN_FRAME_START_I, LIN_FRAME_END_I, LIN_RX_EXPECTED_I, LIN_TX_BIT_I, LIN_TX_DRIVING_I;
   logic LIN_LAST_BYTE_I, LIN_CRC_BAD_I, LIN_CHECKSUM_BAD_I, LIN_TX_WRITE_I, TX_DMA_REQ_I;
   logic RX_DMA_ACK_I, DATA_READ_I, RX_DMA_REQ_O;
   logic [15:0] BAUD_DIV_I;
   logic [7:0] LIN_TX_DATA_I, RX_DATA_O, LIN_TX_READBACK_O;
   lsr_pkg::lsr_flags_type FLAGS_CLEAR_I, FLAGS_O;
   lsr_pkg::lsr_lin_err_type LIN_ERR_CLEAR_I, LIN_ERR_O;
   lsr_pkg::lsr_activity_type ACTIVITY_O;
   int errors = 0, checked = 0, cyc = 0, n;
   ////////////////////////////////////////////////////////////////////////////
   always #5 SYS_CLK_I = ~SYS_CLK_I;
   lsr_receiver uut (.SYS_CLK_I, .RESETN_I, .RXD_I, .BAUD_DIV_I, .PARITY_EN_I, .PARITY_ODD_I, .DMA_RX_EN_I,
      .LIN_MODE_I, .LIN_FRAME_START_I, .LIN_FRAME_END_I, .LIN_RX_EXPECTED_I, .LIN_TX_BIT_I, .LIN_TX_DRIVING_I,
      .LIN_LAST_BYTE_I, .LIN_CRC_BAD_I, .LIN_CHECKSUM_BAD_I, .LIN_TX_WRITE_I, .LIN_TX_DATA_I, .TX_DMA_REQ_I,
      .RX_DMA_ACK_I, .DATA_READ_I, .FLAGS_CLEAR_I, .LIN_ERR_CLEAR_I, .RX_DATA_O, .LIN_TX_READBACK_O, .FLAGS_O,
      .LIN_ERR_O, .ACTIVITY_O, .RX_DMA_REQ_O);
   // Divisor 2 gives 32 clocks per bit
   lsr_line_model #(.BIT_CLKS(32)) lm (.clk_i(SYS_CLK_I), .line_o(RXD_I));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic wt(input int c);
      repeat (c) @(posedge SYS_CLK_I);
      #1;
   endtask
   // Frame plus settling time; flags land well before the stop bit ends
   task automatic frame(input logic [8:0] d, input int nb);
      lm.send(d, nb);
      wt(40);
   endtask
   task automatic clr();
      FLAGS_CLEAR_I = '1;
      LIN_ERR_CLEAR_I = '1;
      DATA_READ_I = 1'b1;
      RX_DMA_ACK_I = 1'b1;
      wt(1);
      {FLAGS_CLEAR_I, LIN_ERR_CLEAR_I, DATA_READ_I, RX_DMA_ACK_I} = '0;
      wt(3);
   endtask
   always @(posedge SYS_CLK_I) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         summarize();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {RESETN_I, PARITY_EN_I, PARITY_ODD_I, DMA_RX_EN_I, LIN_MODE_I, LIN_FRAME_START_I, LIN_FRAME_END_I} = '0;
      {LIN_RX_EXPECTED_I, LIN_TX_BIT_I, LIN_TX_DRIVING_I, LIN_LAST_BYTE_I, LIN_CRC_BAD_I} = '0;
      {LIN_CHECKSUM_BAD_I, LIN_TX_WRITE_I, TX_DMA_REQ_I, RX_DMA_ACK_I, DATA_READ_I} = '0;
      {FLAGS_CLEAR_I, LIN_ERR_CLEAR_I, LIN_TX_DATA_I} = '0;
      BAUD_DIV_I = 16'h0002;
      wt(6);
      RESETN_I = 1'b1;
      wt(400);
      check(FLAGS_O.idle_flag, 1'b0);
      // Tenth stop sample is 154 ticks after the start edge, 16th would be 160
      fork
         lm.send(9'h0a5, 8);
         begin
            n = 0;
            while (FLAGS_O.receive_full_flag !== 1'b1 && n < 400) begin
               wt(1);
               n++;
            end
         end
      join
      check(n >= 306 && n <= 318, 1'b1);
      wt(40);
      check(RX_DATA_O, 8'ha5);
      check(FLAGS_O.idle_flag, 1'b1);
      frame(9'h05a, 8);
      check(FLAGS_O.overrun_flag, 1'b1);
      clr();
      PARITY_EN_I = 1'b1;
      frame(9'h001, 9);
      check(FLAGS_O.parity_error_flag, 1'b1);
      clr();
      PARITY_ODD_I = 1'b1;
      frame(9'h001, 9);
      check(FLAGS_O.parity_error_flag, 1'b0);
      clr();
      PARITY_EN_I = 1'b0;
      DMA_RX_EN_I = 1'b1;
      frame(9'h03c, 8);
      check(RX_DMA_REQ_O, 1'b1);
      check(FLAGS_O.receive_full_flag, 1'b0);
      check(ACTIVITY_O.dma_request_pending, 1'b1);
      frame(9'h0c3, 8);
      check(FLAGS_O.overrun_flag, 1'b1);
      clr();
      check(ACTIVITY_O.dma_request_pending, 1'b0);
      DMA_RX_EN_I = 1'b0;
      // A low shorter than half a bit is a false start and leaves no byte
      lm.line_o = 1'b0;
      wt(8);
      lm.line_o = 1'b1;
      wt(400);
      check(FLAGS_O.receive_full_flag, 1'b0);
      frame(9'h000, 9);
      check(FLAGS_O.frame_error_flag, 1'b1);
      clr();
      TX_DMA_REQ_I = 1'b1;
      wt(3);
      check(ACTIVITY_O.dma_request_pending, 1'b1);
      TX_DMA_REQ_I = 1'b0;
      LIN_TX_WRITE_I = 1'b1;
      LIN_TX_DATA_I = 8'h3c;
      wt(1);
      LIN_TX_DATA_I = 8'hc3;
      wt(1);
      LIN_TX_WRITE_I = 1'b0;
      wt(2);
      check(LIN_TX_READBACK_O, 8'hc3);
      LIN_MODE_I = 1'b1;
      frame(9'h055, 8);
      check(LIN_ERR_O.unrequested_data_flag, 1'b1);
      clr();
      LIN_FRAME_START_I = 1'b1;
      wt(1);
      LIN_FRAME_START_I = 1'b0;
      wt(3);
      check(ACTIVITY_O.lin_transaction_active, 1'b1);
      {LIN_RX_EXPECTED_I, LIN_CRC_BAD_I, LIN_CHECKSUM_BAD_I, LIN_LAST_BYTE_I} = '1;
      frame(9'h055, 8);
      check(FLAGS_O.lin_receive_ready_flag, 1'b1);
      check(LIN_ERR_O, 8'h03);
      clr();
      DMA_RX_EN_I = 1'b1;
      frame(9'h055, 8);
      check(FLAGS_O.lin_receive_ready_flag, 1'b0);
      clr();
      {DMA_RX_EN_I, LIN_RX_EXPECTED_I, LIN_CRC_BAD_I, LIN_CHECKSUM_BAD_I, LIN_LAST_BYTE_I} = '0;
      {LIN_TX_DRIVING_I, LIN_TX_BIT_I} = '1;
      frame(9'h000, 8);
      check(LIN_ERR_O.lin_bit_error_flag, 1'b1);
      clr();
      {LIN_TX_DRIVING_I, LIN_TX_BIT_I} = '0;
      frame(9'h000, 8);
      check(LIN_ERR_O.lin_frame_overflow_flag, 1'b1);
      LIN_FRAME_END_I = 1'b1;
      wt(1);
      LIN_FRAME_END_I = 1'b0;
      wt(3);
      check(ACTIVITY_O.lin_transaction_active, 1'b0);
      clr();
      // Long low outside a transaction is a wake-up; the receiver still starts a byte on it
      lm.line_o = 1'b0;
      wt(60);
      check(ACTIVITY_O.lin_wakeup_active, 1'b1);
      lm.line_o = 1'b1;
      wt(12);
      check(ACTIVITY_O.lin_wakeup_active, 1'b0);
      summarize();
   end
endmodule // lsr_receiver_test
bind lsr_receiver lsr_receiver_props chk (.SYS_CLK_I, .RESETN_I, .RXD_I, .DMA_RX_EN_I, .LIN_MODE_I,
   .LIN_FRAME_START_I, .LIN_FRAME_END_I, .LIN_TX_WRITE_I, .LIN_TX_DATA_I, .TX_DMA_REQ_I, .LIN_TX_READBACK_O,
   .FLAGS_O, .LIN_ERR_O, .ACTIVITY_O, .RX_DMA_REQ_O);
